// ### logic/clkpm_pkg.sv
/*
 clock source and power-mode control: shared constants, types and carriers.
 assumes core_clk at 10 MHz stands for the selected oscillator source.
*/
package clkpm_pkg;

   // timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int WAKE_DELAY_NS  = 10000;
   localparam int WAKE_DELAY_CYC = (WAKE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1
                                   : WAKE_DELAY_NS / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W     = $clog2(WAKE_DELAY_CYC + 1);
   localparam int OST_COUNT      = 1024;
   localparam int POR_PULSE_CYC  = 16;
   localparam int OSC_DIV        = 4;

   // control register layout
   localparam int IDLE_BIT_POS   = 7;
   localparam int READY_BIT_POS  = 3;
   localparam int SEL_LSB_POS    = 0;
   localparam int SEL_MSB_POS    = 1;
   localparam logic       IDLE_RST  = 1'h0;
   localparam logic [1:0] SEL_RST   = 2'h0;
   localparam logic [1:0] SEL_PRIM  = 2'h0;
   localparam logic [1:0] SEL_SECND = 2'h1;

   typedef enum logic [2:0] {
      ext_clock_mode,
      ext_clock_portpin_mode,
      rc_osc_mode,
      rc_osc_portpin_mode,
      crystal_mode
   } osc_mode_t;

   typedef enum logic [1:0] {
      src_primary,
      src_secondary,
      src_internal,
      src_none
   } sys_src_t;

   typedef struct packed {
      logic     cpu_clk_en;
      logic     periph_clk_en;
      logic     primary_osc_en;
      sys_src_t sys_src;
      logic     primary_clock_ready_flag;
      logic     cpu_ready;
   } pm_status_t;

   typedef struct packed {
      logic irq;
      logic wdt;
   } wake_src_t;

endpackage : clkpm_pkg

// ### logic/sync_2ff.sv
/*
 two flip-flop synchroniser for asynchronous levels.
 assumes rst_n is already synchronous to clk; en freezes both stages.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else if (en)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync_2ff
`default_nettype wire

// ### logic/clock_power_ctrl.sv
/*
 clock source selection, sleep and idle control, wake-up sequencing,
 oscillator pin use and power-on reset pulse.
 assumes the sleep instruction, wake requests and register writes come
 from core logic on core_clk; osc_in_pin, supply_ok and the port pin are
 asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - external-clock modes: primary ready at once, no start-up delay
// R2 - external-clock mode drives oscillator divided by four on output pin
// R3 - external-clock port-pin mode frees output pin as port A bit 6
// R4 - rc mode drives oscillator divided by four on output pin
// R5 - rc port-pin mode frees output pin as port A bit 6
// R6 - sleep instruction with idle bit and select bits 000 enters Sleep
// R7 - entering Sleep stops primary oscillator and clears ready flag
// R8 - Sleep wake: unclocked until ready, or internal block if enabled
// R9 - ready flag set once primary clock supplies the system; here set when prim_on and start-up are done, before the switch
// R10 - wake-up leaves idle bit and clock-select bits unchanged
// R11 - peripherals stay clocked while running regardless of idle bit
// R12 - sleep with idle bit set stops CPU, peripherals on selected source
// R13 - Idle left only by interrupt, watchdog time-out or reset
// R14 - CPU execution starts about 10 us after a wake-up event
// R15 - after Idle wake, run from idle source until primary ready
// R16 - watchdog time-out in Idle or Sleep wakes instead of reset
// R17 - power-on reset pulse generated when supply rise is detected
// R18 - crystal modes count 1024 oscillator cycles before primary ready
// R19 - ready indication synchronised before switching clock source
module clock_power_ctrl
   import clkpm_pkg::*;
#(
   parameter int OST_CYCLES = OST_COUNT,
   parameter int POR_CYCLES = POR_PULSE_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire osc_mode_t  osc_mode,
   input  wire logic       osc_wr,
   input  wire logic [7:0] osc_wdata,
   output logic      [7:0] oscillator_control_reg,
   input  wire logic       sleep_instr,
   input  wire wake_src_t  wake_src,
   input  wire logic       two_speed_en,
   input  wire logic       fail_safe_en,
   input  wire logic       osc_in_pin,
   input  wire logic       supply_ok,
   output logic            osc_out_pin_o,
   output logic            osc_out_pin_oe_n,
   input  wire logic       port_a_bit6_out,
   input  wire logic       port_a_bit6_drive,
   output logic            port_a_bit6_in,
   output pm_status_t      pm_status,
   output logic            wdt_reset,
   output logic            por_pulse
);

   localparam int OST_W = $clog2(OST_CYCLES);
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam int WAKE_CYC = WAKE_DELAY_CYC;

   // the pulse check below watches eight cycles of por_pulse
   if (OST_CYCLES < 2 || POR_CYCLES < 8)
   begin : g_param_check
      $error("clock_power_ctrl: needs OST_CYCLES >= 2, POR_CYCLES >= 8");
   end

   typedef enum logic [1:0] {st_run, st_sleep, st_idle, st_wake} pm_state_t;

   function automatic sys_src_t src_of(input logic [1:0] sel);
      if (sel == SEL_PRIM)
         return src_primary;
      else if (sel == SEL_SECND)
         return src_secondary;
      else
         return src_internal;
   endfunction : src_of

   // reset release through two flops
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // pin inputs
   logic [2:0] pin_sync;
   wire        osc_in_s  = pin_sync[0];
   wire        supply_s  = pin_sync[1];
   wire        port_in_s = pin_sync[2];

   // R19 ready path built only from synchronised oscillator edges
   sync_2ff #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .en    (clk_en),
      .d     ({port_a_bit6_drive ? port_a_bit6_out : 1'b0, supply_ok,
               osc_in_pin}),
      .q     (pin_sync)
   );

   // control bits
   logic        idle_enable_q;
   logic [1:0]  clock_select_q;
   pm_state_t   state_q;
   pm_state_t   state_d;
   logic        from_sleep_q;
   logic        prim_forced_q;
   logic        ready_q;
   logic        ready_d;
   logic [OST_W-1:0]      ost_cnt_q;
   logic                  osc_prev_q;
   logic [WAKE_CNT_W-1:0] wake_cnt_q;
   logic [1:0]            div_q;
   logic                  supply_prev_q;
   logic [POR_W-1:0]      por_cnt_q;

   wire wake_any   = wake_src.irq | wake_src.wdt;
   wire osc_edge   = osc_in_s & ~osc_prev_q;
   wire is_crystal = (osc_mode == crystal_mode);
   wire pin_div4   = (osc_mode == ext_clock_mode) ||
                     (osc_mode == rc_osc_mode);
   wire pin_port   = (osc_mode == ext_clock_portpin_mode) ||
                     (osc_mode == rc_osc_portpin_mode);
   wire enter_wake = (state_q == st_sleep || state_q == st_idle) && wake_any;
   wire cpu_ready  = (wake_cnt_q == '0);

   // R10 only software writes touch these; wake-up never does
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idle_enable_q  <= IDLE_RST;
         clock_select_q <= SEL_RST;
      end
      else if (clk_en && osc_wr)
      begin
         idle_enable_q  <= osc_wdata[IDLE_BIT_POS];
         clock_select_q <= osc_wdata[SEL_MSB_POS:SEL_LSB_POS];
      end
   end

   // power-mode sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         st_run:
            // R6 idle bit clear: sleep; R12 idle bit set: idle
            if (sleep_instr)
               state_d = idle_enable_q ? st_idle : st_sleep;
         st_sleep, st_idle:
            // R13 only interrupt or watchdog leaves; reset is arst_n
            if (wake_any)
               state_d = st_wake;
         st_wake:
            // R15 switch to primary once the ready flag is set
            if (ready_q)
               state_d = st_run;
         default:
            state_d = st_wake;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q       <= st_wake;
         from_sleep_q  <= 1'b1;
         prim_forced_q <= 1'b1;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         if (enter_wake)
            from_sleep_q <= (state_q == st_sleep);
         // wake wins over a write in the same cycle
         if (enter_wake)
            prim_forced_q <= 1'b1;
         else if (osc_wr)
            prim_forced_q <= 1'b0;
      end
   end

   // primary oscillator and clock routing
   wire        prim_on = (state_q == st_run) || (state_q == st_wake) ||
                         (state_q == st_idle && clock_select_q == SEL_PRIM);
   sys_src_t   src_sel;

   always_comb
   begin
      case (state_q)
         // R15 after a wake, primary until software rewrites the select
         st_run:   src_sel = prim_forced_q ? src_primary
                             : src_of(clock_select_q);
         st_idle:  src_sel = src_of(clock_select_q);
         st_sleep: src_sel = src_none;
         // R8 sleep wake: none, or internal block with two-speed or monitor
         st_wake:  src_sel = !from_sleep_q ? src_of(clock_select_q)
                             : (two_speed_en || fail_safe_en) ? src_internal
                             : src_none;
         default:  src_sel = src_none;
      endcase
   end

   // R18 crystal start-up counted on synchronised oscillator edges
   always_comb
   begin
      ready_d = ready_q;
      // R7 oscillator stopped clears the flag
      if (!prim_on)
         ready_d = 1'b0;
      // R1 external clock and rc need no start-up count
      else if (!is_crystal)
         ready_d = 1'b1;
      else if (osc_edge && ost_cnt_q == OST_W'(OST_CYCLES - 1))
         ready_d = 1'b1;
   end

   // R9 flag set once the primary runs and start-up is done, before the source switch
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ready_q    <= 1'b0;
         ost_cnt_q  <= '0;
         osc_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ready_q    <= ready_d;
         osc_prev_q <= osc_in_s;
         if (!prim_on || ready_q)
            ost_cnt_q <= '0;
         else if (osc_edge)
            ost_cnt_q <= ost_cnt_q + OST_W'(1);
      end
   end

   // R14 cpu held off for the wake delay
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wake_cnt_q <= '0;
      else if (clk_en)
      begin
         if (enter_wake)
            wake_cnt_q <= WAKE_CNT_W'(WAKE_CYC);
         else if (!cpu_ready)
            wake_cnt_q <= wake_cnt_q - WAKE_CNT_W'(1);
      end
   end

   // status: cpu runs only when awake, past the delay and clocked
   wire cpu_on    = (state_q == st_run || state_q == st_wake) &&
                    cpu_ready && src_sel != src_none;
   // R11 peripherals follow the source in every state but sleep
   wire periph_on = (state_q != st_sleep) && src_sel != src_none;

   always_comb
   begin
      pm_status.cpu_clk_en               = cpu_on;
      pm_status.periph_clk_en            = periph_on;
      pm_status.primary_osc_en           = prim_on;
      pm_status.sys_src                  = src_sel;
      pm_status.primary_clock_ready_flag = ready_q;
      pm_status.cpu_ready                = cpu_ready;
   end

   always_comb
   begin
      oscillator_control_reg                = 8'h00;
      oscillator_control_reg[IDLE_BIT_POS]  = idle_enable_q;
      oscillator_control_reg[READY_BIT_POS] = ready_q;
      oscillator_control_reg[SEL_MSB_POS:SEL_LSB_POS] = clock_select_q;
   end

   // oscillator output pin; divider stops with the oscillator
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= 2'h0;
      else if (clk_en)
         div_q <= prim_on ? div_q + 2'h1 : 2'h0;
   end

   logic pin_q;
   logic pin_oe_n_q;
   logic port_in_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_q      <= 1'b0;
         pin_oe_n_q <= 1'b1;
         port_in_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         // R2 R4 divide by four drives the pin
         if (pin_div4)
         begin
            pin_q      <= div_q[1];
            pin_oe_n_q <= 1'b0;
         end
         // R3 R5 pin handed to port A bit 6
         else if (pin_port)
         begin
            pin_q      <= port_a_bit6_out;
            pin_oe_n_q <= ~port_a_bit6_drive;
         end
         else
         begin
            pin_q      <= 1'b0;
            pin_oe_n_q <= 1'b1;
         end
         port_in_q <= pin_port & port_in_s;
      end
   end

   assign osc_out_pin_o    = pin_q;
   assign osc_out_pin_oe_n = pin_oe_n_q;
   assign port_a_bit6_in   = port_in_q;

   // watchdog: reset only from a running state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wdt_reset <= 1'b0;
      else if (clk_en)
         // R16 sleep and idle treat time-out as wake
         wdt_reset <= wake_src.wdt &&
                      (state_q == st_run || state_q == st_wake);
   end

   // R17 pulse on each supply rise seen after synchronising
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_prev_q <= 1'b0;
         por_cnt_q     <= '0;
      end
      else if (clk_en)
      begin
         supply_prev_q <= supply_s;
         if (supply_s && !supply_prev_q)
            por_cnt_q <= POR_W'(POR_CYCLES);
         else if (por_cnt_q != '0)
            por_cnt_q <= por_cnt_q - POR_W'(1);
      end
   end

   assign por_pulse = (por_cnt_q != '0);

   // checks; a frozen clock enable suspends them
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n || !clk_en);

   sequence s_wake_start;
      enter_wake;
   endsequence

   sequence s_cpu_held;
      !cpu_ready [*8];
   endsequence

   chk_sleep_entry: assert property ( // R6
      state_q == st_run && sleep_instr && !idle_enable_q |=>
      state_q == st_sleep)
      else $error("sleep not entered");

   chk_sleep_stops_osc: assert property ( // R7
      $rose(state_q == st_sleep) |-> !prim_on ##1 !ready_q)
      else $error("oscillator or ready flag not cleared in sleep");

   chk_sleep_wake_clk: assert property ( // R8
      state_q == st_wake && from_sleep_q && !two_speed_en &&
      !fail_safe_en |-> !pm_status.cpu_clk_en && !pm_status.periph_clk_en)
      else $error("clock active before primary ready");

   chk_ready_switch: assert property ( // R15
      state_q == st_wake && ready_q |=>
      state_q == st_run && src_sel == src_primary)
      else $error("no switch after ready");

   chk_idle_cpu_off: assert property ( // R12
      state_q == st_idle |-> !pm_status.cpu_clk_en &&
      pm_status.periph_clk_en == (src_sel != src_none))
      else $error("idle clocking wrong");

   chk_wdt_wakes: assert property ( // R16
      (state_q == st_sleep || state_q == st_idle) && wake_src.wdt |=>
      state_q == st_wake && !wdt_reset)
      else $error("watchdog reset in power-managed mode");

   chk_cpu_delay: assert property ( // R14
      s_wake_start |=> s_cpu_held ##[1:WAKE_CYC] cpu_ready)
      else $error("wake delay wrong");

   chk_no_startup: assert property ( // R1
      prim_on && !is_crystal && !ready_q |=> ready_q)
      else $error("start-up delay in external or rc mode");

   chk_ost_count: assert property ( // R18
      $rose(ready_q) && is_crystal |->
      $past(ost_cnt_q) == OST_W'(OST_CYCLES - 1))
      else $error("ready before start-up count");

   chk_por_pulse: assert property ( // R17
      supply_s && !supply_prev_q |=> por_pulse [*8])
      else $error("power-on pulse too short");

endmodule : clock_power_ctrl
`default_nettype wire

// ### sim/osc_source_model.sv
/*
 behavioural external clock source or rc network on the oscillator input.
 assumes run is high while the far side oscillates; it stands still
 at low otherwise, as a stopped rc network or gated source would.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_source_model #(
   parameter int HALF_NS = 150
) (
   input  wire logic run,
   output var  logic osc
);

   initial osc = 1'h0;

   // half period three times that of core_clk
   always
   begin
      #HALF_NS;
      osc = run ? ~osc : 1'h0;
   end

endmodule : osc_source_model
`default_nettype wire

// ### sim/clock_source_power_mode_control_bench.sv
/*
 self-checking bench for clock_power_ctrl: oscillator modes, sleep,
 idle, wake-up timing and power-on pulse.
 assumes the design's own assertions run alongside; start-up count
 shortened to 4 oscillator edges.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_source_power_mode_control_bench;
   import clkpm_pkg::*;

   typedef struct packed {
      logic [3:0] sel;
      logic [7:0] val;
   } note_t;

   logic       core_clk;
   logic       arst_n;
   logic       clk_en;
   osc_mode_t  osc_mode;
   logic       osc_wr;
   logic [7:0] osc_wdata;
   logic [7:0] oscillator_control_reg;
   logic       sleep_instr;
   wake_src_t  wake_src;
   logic       two_speed_en;
   logic       fail_safe_en;
   logic       osc_in_pin;
   logic       supply_ok;
   logic       osc_out_pin_o;
   logic       osc_out_pin_oe_n;
   logic       port_a_bit6_out;
   logic       port_a_bit6_drive;
   logic       port_a_bit6_in;
   pm_status_t pm_status;
   logic       wdt_reset;
   logic       por_pulse;
   logic       osc_run;
   logic [31:0] seed;
   note_t      notes[$];
   note_t      nt;
   int         n_mismatch;
   int         n_tests;

   clock_power_ctrl #(.OST_CYCLES(4), .POR_CYCLES(16)) u_clock_power_ctrl (
      .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
      .osc_mode(osc_mode), .osc_wr(osc_wr), .osc_wdata(osc_wdata),
      .oscillator_control_reg(oscillator_control_reg),
      .sleep_instr(sleep_instr), .wake_src(wake_src),
      .two_speed_en(two_speed_en), .fail_safe_en(fail_safe_en),
      .osc_in_pin(osc_in_pin), .supply_ok(supply_ok),
      .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_n(osc_out_pin_oe_n),
      .port_a_bit6_out(port_a_bit6_out),
      .port_a_bit6_drive(port_a_bit6_drive),
      .port_a_bit6_in(port_a_bit6_in), .pm_status(pm_status),
      .wdt_reset(wdt_reset), .por_pulse(por_pulse));

   // an external source runs on its own; rc and crystal follow the enable
   assign osc_run = (osc_mode == ext_clock_mode ||
                     osc_mode == ext_clock_portpin_mode) ? 1'h1
                    : pm_status.primary_osc_en;

   osc_source_model #(.HALF_NS(150)) u_osc_source_model (
      .run(osc_run), .osc(osc_in_pin));

   initial core_clk = 1'h0;
   always #50 core_clk = ~core_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] pick(input int sel);
      case (sel)
         0:       return oscillator_control_reg;
         1:       return {7'h0, pm_status.primary_clock_ready_flag};
         2:       return {7'h0, pm_status.cpu_clk_en};
         3:       return {7'h0, pm_status.periph_clk_en};
         4:       return {7'h0, pm_status.primary_osc_en};
         5:       return {6'h0, pm_status.sys_src};
         6:       return {7'h0, pm_status.cpu_ready};
         7:       return {7'h0, osc_out_pin_o};
         8:       return {7'h0, osc_out_pin_oe_n};
         9:       return {7'h0, wdt_reset};
         10:      return {7'h0, por_pulse};
         default: return {7'h0, port_a_bit6_in};
      endcase
   endfunction : pick

   function automatic string name_of(input int sel);
      case (sel)
         0:       return "oscillator_control_reg";
         1:       return "ready_flag";
         2:       return "cpu_clk_en";
         3:       return "periph_clk_en";
         4:       return "primary_osc_en";
         5:       return "sys_src";
         6:       return "cpu_ready";
         7:       return "osc_out_pin_o";
         8:       return "osc_out_pin_oe_n";
         9:       return "wdt_reset";
         10:      return "por_pulse";
         default: return "port_a_bit6_in";
      endcase
   endfunction : name_of

   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input int id);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name_of(id), exp, seen);
      end
   endtask : check

   // a note is taken off at the falling edge after the edge that queued it
   always @(negedge core_clk)
      while (notes.size() > 0)
      begin
         nt = notes.pop_front();
         check(pick(int'(nt.sel)), nt.val, int'(nt.sel));
      end

   task automatic want(input int sel, input logic [7:0] v);
      notes.push_back({sel[3:0], v});
   endtask : want

   task automatic wait_for(input int sel, input logic [7:0] v,
                           input int lim);
      int k;
      k = 0;
      @(negedge core_clk);
      while (pick(sel) !== v && k < lim)
      begin
         k++;
         @(negedge core_clk);
      end
      if (pick(sel) !== v)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask : wait_for

   task automatic do_reset;
      @(posedge core_clk);
      arst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge core_clk);
   endtask : do_reset

   task automatic wr(input logic [7:0] v);
      @(posedge core_clk);
      osc_wr    <= 1'h1;
      osc_wdata <= v;
      @(posedge core_clk);
      osc_wr    <= 1'h0;
   endtask : wr

   task automatic pulse(input int which, input logic [1:0] w);
      @(posedge core_clk);
      if (which == 0)
         sleep_instr <= 1'h1;
      else
         wake_src <= w;
      @(posedge core_clk);
      sleep_instr <= 1'h0;
      wake_src    <= 2'h0;
   endtask : pulse

   initial
   begin : main
      int m;
      int cnt;
      logic b;
      n_mismatch = 0;
      n_tests = 0;
      seed = 32'h0001_0C60;
      arst_n = 1'h0;
      clk_en = 1'h1;
      osc_mode = ext_clock_mode;
      osc_wr = 1'h0;
      osc_wdata = 8'h00;
      sleep_instr = 1'h0;
      wake_src = 2'h0;
      two_speed_en = 1'h0;
      fail_safe_en = 1'h0;
      supply_ok = 1'h0;
      port_a_bit6_out = 1'h0;
      port_a_bit6_drive = 1'h0;
      for (m = 0; m < 5; m++)
      begin
         osc_mode <= osc_mode_t'(m);
         do_reset();
         if (m == 4)
         begin
            want(1, 8'h00);
            wait_for(1, 8'h01, 60);
            @(posedge core_clk);
            want(8, 8'h01);
         end
         else
            want(1, 8'h01);
         if (m == 0 || m == 2)
         begin
            cnt = 0;
            @(posedge core_clk);
            want(8, 8'h00);
            // 40 cycles at a quarter of the clock hold exactly ten rises
            b = osc_out_pin_o;
            repeat (40)
            begin
               @(negedge core_clk);
               if (osc_out_pin_o === 1'h1 && b === 1'h0)
                  cnt++;
               b = osc_out_pin_o;
            end
            check(cnt[7:0], 8'h0A, 7);
         end
         // output pin freed for port bit
         if (m == 1 || m == 3)
         begin
            seed = lfsr(seed);
            b = seed[0];
            @(posedge core_clk);
            port_a_bit6_out   <= b;
            port_a_bit6_drive <= 1'h1;
            repeat (2) @(posedge core_clk);
            want(7, {7'h0, b});
            want(8, 8'h00);
            port_a_bit6_drive <= 1'h0;
            repeat (2) @(posedge core_clk);
            want(8, 8'h01);
            want(11, {7'h0, b});
         end
      end
      osc_mode <= ext_clock_mode;
      do_reset();
      repeat (4)
      begin
         seed = lfsr(seed);
         wr(seed[7:0]);
         want(0, {seed[7], 3'h0, 1'h1, 1'h0, seed[1:0]});
         want(3, 8'h01);
      end
      // sleep entry and the three wake-up clock choices
      for (m = 0; m < 3; m++)
      begin
         two_speed_en <= (m == 1);
         fail_safe_en <= (m == 2);
         wr(8'h00);
         pulse(0, 2'h0);
         repeat (2) @(posedge core_clk);
         want(4, 8'h00);
         want(1, 8'h00);
         want(2, 8'h00);
         want(3, 8'h00);
         pulse(1, (m == 0) ? 2'h1 : 2'h2);
         want(5, {6'h0, (m == 0) ? src_none : src_internal});
         want(9, 8'h00);
         want(6, 8'h00);
         repeat (WAKE_DELAY_CYC - 3) @(posedge core_clk);
         want(6, 8'h00);
         wait_for(6, 8'h01, 6);
         @(posedge core_clk);
         want(0, 8'h08);
         want(1, 8'h01);
         want(2, 8'h01);
         want(4, 8'h01);
      end
      wr(8'h81);
      want(0, 8'h89);
      pulse(0, 2'h0);
      repeat (2) @(posedge core_clk);
      want(2, 8'h00);
      want(3, 8'h01);
      want(5, {6'h0, src_secondary});
      // a wake request while the clock enable is low must be lost
      clk_en <= 1'h0;
      pulse(1, 2'h2);
      want(5, {6'h0, src_secondary});
      clk_en <= 1'h1;
      repeat (20) @(posedge core_clk);
      want(2, 8'h00);
      pulse(1, 2'h2);
      want(5, {6'h0, src_secondary});
      wait_for(1, 8'h01, 20);
      repeat (2) @(posedge core_clk);
      want(5, {6'h0, src_primary});
      want(0, 8'h89);
      wait_for(6, 8'h01, WAKE_DELAY_CYC + 8);
      pulse(1, 2'h1);
      wait_for(9, 8'h01, 3);
      @(posedge core_clk);
      supply_ok <= 1'h1;
      wait_for(10, 8'h01, 8);
      cnt = 0;
      while (por_pulse === 1'h1 && cnt < 40)
      begin
         cnt++;
         @(negedge core_clk);
      end
      check(cnt[7:0], 8'h10, 10);
      repeat (2) @(posedge core_clk);
      complete_run();
   end : main

endmodule : clock_source_power_mode_control_bench
`default_nettype wire
